// file: tcc_channel_ctl.v
// Control and status registers of capture/compare channels 3 and 4, APB slave
//
// Notes on behaviour
// R1 - Edge field picks none, rising, falling, both
// R2 - Source field picks A, B, ground, supply
// R3 - Sync bit adds one extra register stage on the selected input
// R4 - Latched bit samples input on match
// R5 - Bit 9 always reads zero
// R6 - Mode bit: zero compare, one capture
// R7 - Three-bit field selects eight output modes
// R8 - Enable bit gates event flag to interrupt; gates ch3_irq_req/ch4_irq_req only, irq is masked by irq_mask_r instead
// R9 - Bit 3 shows live selected input
// R10 - Mode zero: drive bit sets output
// R11 - Overrun set by hardware, cleared by software
// R12 - Event flag shows pending, software writable
// R13 - Both registers reset to zero
// R14 - Capture while flag set means overrun
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.vh"
module tcc_channel_ctl (
  input  wire        clock,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Channel inputs, asynchronous pins
  input  wire        ch3_input_a_line,
  input  wire        ch3_input_b_line,
  input  wire        ch4_input_a_line,
  input  wire        ch4_input_b_line,
  // Timer events, same clock domain
  input  wire        ch3_match_pulse,
  input  wire        ch4_match_pulse,
  input  wire        period_pulse,
  // Results
  output reg         ch3_capture_pulse,
  output reg         ch4_capture_pulse,
  output wire        ch3_out,
  output wire        ch4_out,
  output wire        ch3_irq_req,
  output wire        ch4_irq_req,
  output wire        irq
);

  // =========================================================
  // Helper functions
  function sel_input;
    input [1:0] src;
    input       line_a;
    input       line_b;
    begin
      case (src)
        `TCC_SRC_A:   sel_input = line_a;
        `TCC_SRC_B:   sel_input = line_b;
        `TCC_SRC_GND: sel_input = 1'b0;
        default:      sel_input = 1'b1;
      endcase
    end
  endfunction

  function edge_hit;
    input [1:0] mode;
    input       now;
    input       prev;
    begin
      case (mode)
        `TCC_EDGE_RISE: edge_hit = now & ~prev;
        `TCC_EDGE_FALL: edge_hit = ~now & prev;
        `TCC_EDGE_BOTH: edge_hit = now ^ prev;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Control word with live and reserved bits forced
  function [15:0] ctl_view;
    input [15:0] stored;
    input        live;
    begin
      ctl_view = stored;
      ctl_view[`TCC_RSVD_BIT] = 1'b0;
      ctl_view[`TCC_LIVE_BIT] = live;
    end
  endfunction

  // =========================================================
  // Input synchronisers on all pins
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {ch4_input_b_line, ch4_input_a_line, ch3_input_b_line, ch3_input_a_line};
      pin_s2_r <= pin_s1_r;
    end
  end

  // =========================================================
  // Registers
  reg  [15:0] ch3_ctl_r;
  reg  [15:0] ch4_ctl_r;
  reg  [3:0]  irq_stat_r;
  reg  [3:0]  irq_mask_r;
  reg  [1:0]  sync_x_r;
  reg  [1:0]  prev_in_r;
  wire        ch3_sel;
  wire        ch4_sel;
  wire [1:0]  cap_in;
  wire        ch3_cap;
  wire        ch4_cap;

  assign ch3_sel = sel_input(ch3_ctl_r[`TCC_SRC_HI:`TCC_SRC_LO],
                             pin_s2_r[0], pin_s2_r[1]); // R2
  assign ch4_sel = sel_input(ch4_ctl_r[`TCC_SRC_HI:`TCC_SRC_LO],
                             pin_s2_r[2], pin_s2_r[3]); // R2

  // Extra register stage when synchronous capture is selected; the pin
  // synchroniser is always present because pins can never be read raw here.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_x_r  <= 2'h0;
      prev_in_r <= 2'h0;
    end else begin
      sync_x_r  <= {ch4_sel, ch3_sel};
      prev_in_r <= cap_in;
    end
  end

  assign cap_in[0] = ch3_ctl_r[`TCC_SYNC_BIT] ? sync_x_r[0] : ch3_sel; // R3
  assign cap_in[1] = ch4_ctl_r[`TCC_SYNC_BIT] ? sync_x_r[1] : ch4_sel; // R3

  assign ch3_cap = ch3_ctl_r[`TCC_MODE_BIT] &
                   edge_hit(ch3_ctl_r[`TCC_EDGE_HI:`TCC_EDGE_LO], cap_in[0], prev_in_r[0]); // R1 R6
  assign ch4_cap = ch4_ctl_r[`TCC_MODE_BIT] &
                   edge_hit(ch4_ctl_r[`TCC_EDGE_HI:`TCC_EDGE_LO], cap_in[1], prev_in_r[1]); // R1 R6

  // =========================================================
  // APB decode; zero wait states
  wire        acc;
  wire        wr;
  wire        wr_ch3;
  wire        wr_ch4;
  wire        wr_stat;
  wire        wr_mask;
  wire        addr_ok;
  wire [1:0]  ev_set;
  wire [1:0]  ovr_set;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign wr_ch3  = wr & (paddr == `TCC_CH3_CTL_ADDR);
  assign wr_ch4  = wr & (paddr == `TCC_CH4_CTL_ADDR);
  assign wr_stat = wr & (paddr == `TCC_IRQ_STAT_ADDR);
  assign wr_mask = wr & (paddr == `TCC_IRQ_MASK_ADDR);
  assign addr_ok = (paddr == `TCC_CH3_CTL_ADDR) | (paddr == `TCC_CH4_CTL_ADDR) |
                   (paddr == `TCC_IRQ_STAT_ADDR) | (paddr == `TCC_IRQ_MASK_ADDR);
  assign pready  = 1'b1;
  assign pslverr = acc & ~addr_ok;

  // Capture mode: edge sets flag; compare mode: match sets flag
  assign ev_set[0] = ch3_ctl_r[`TCC_MODE_BIT] ? ch3_cap : ch3_match_pulse;
  assign ev_set[1] = ch4_ctl_r[`TCC_MODE_BIT] ? ch4_cap : ch4_match_pulse;
  assign ovr_set[0] = ch3_cap & ch3_ctl_r[`TCC_FLAG_BIT]; // R14
  assign ovr_set[1] = ch4_cap & ch4_ctl_r[`TCC_FLAG_BIT]; // R14

  // =========================================================
  // Control register update; hardware set wins over software clear
  reg [15:0] ch3_nxt;
  reg [15:0] ch4_nxt;

  always @* begin
    ch3_nxt = ch3_ctl_r;
    ch4_nxt = ch4_ctl_r;
    if (wr_ch3) begin
      ch3_nxt = (ch3_ctl_r & ~`TCC_CTL_WMASK) | (pwdata[15:0] & `TCC_CTL_WMASK); // R12
    end
    if (wr_ch4) begin
      ch4_nxt = (ch4_ctl_r & ~`TCC_CTL_WMASK) | (pwdata[15:0] & `TCC_CTL_WMASK); // R12
    end
    if (ch3_match_pulse) begin
      ch3_nxt[`TCC_LATCH_BIT] = cap_in[0]; // R4
    end
    if (ch4_match_pulse) begin
      ch4_nxt[`TCC_LATCH_BIT] = cap_in[1]; // R4
    end
    if (ev_set[0]) ch3_nxt[`TCC_FLAG_BIT] = 1'b1; // R12
    if (ev_set[1]) ch4_nxt[`TCC_FLAG_BIT] = 1'b1; // R12
    if (ovr_set[0]) ch3_nxt[`TCC_OVR_BIT] = 1'b1; // R11
    if (ovr_set[1]) ch4_nxt[`TCC_OVR_BIT] = 1'b1; // R11
    ch3_nxt[`TCC_RSVD_BIT] = 1'b0; // R5
    ch4_nxt[`TCC_RSVD_BIT] = 1'b0; // R5
    ch3_nxt[`TCC_LIVE_BIT] = 1'b0;
    ch4_nxt[`TCC_LIVE_BIT] = 1'b0;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch3_ctl_r <= `TCC_CTL_RESET; // R13
      ch4_ctl_r <= `TCC_CTL_RESET; // R13
    end else begin
      ch3_ctl_r <= ch3_nxt;
      ch4_ctl_r <= ch4_nxt;
    end
  end

  // =========================================================
  // Interrupt status, write one to clear; set beats clear
  wire [3:0] stat_set;
  assign stat_set = {ovr_set, ev_set};

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= `TCC_IRQ_RESET;
      irq_mask_r <= `TCC_IRQ_RESET;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? pwdata[3:0] : 4'h0)) | stat_set;
      if (wr_mask) begin
        irq_mask_r <= pwdata[3:0];
      end
    end
  end

  assign ch3_irq_req = ch3_ctl_r[`TCC_IE_BIT] & ch3_ctl_r[`TCC_FLAG_BIT]; // R8
  assign ch4_irq_req = ch4_ctl_r[`TCC_IE_BIT] & ch4_ctl_r[`TCC_FLAG_BIT]; // R8
  assign irq = |(irq_stat_r & irq_mask_r);

  // =========================================================
  // Capture pulse out, for the counter snapshot
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch3_capture_pulse <= 1'b0;
      ch4_capture_pulse <= 1'b0;
    end else begin
      ch3_capture_pulse <= ch3_cap;
      ch4_capture_pulse <= ch4_cap;
    end
  end

  // =========================================================
  // Read data, registered on setup phase
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TCC_CH3_CTL_ADDR:  prdata <= {16'h0000, ctl_view(ch3_ctl_r, cap_in[0])}; // R9 R5
        `TCC_CH4_CTL_ADDR:  prdata <= {16'h0000, ctl_view(ch4_ctl_r, cap_in[1])}; // R9 R5
        `TCC_IRQ_STAT_ADDR: prdata <= {28'h0000000, irq_stat_r};
        `TCC_IRQ_MASK_ADDR: prdata <= {28'h0000000, irq_mask_r};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end

  // =========================================================
  // Output units
  tcc_out_unit u_out3 (
    .clock        (clock),
    .resetn       (resetn),
    .out_mode     (ch3_ctl_r[`TCC_OMODE_HI:`TCC_OMODE_LO]), // R7
    .drive_bit    (ch3_ctl_r[`TCC_DRIVE_BIT]), // R10
    .match_pulse  (ch3_match_pulse),
    .period_pulse (period_pulse),
    .out_level    (ch3_out)
  );

  tcc_out_unit u_out4 (
    .clock        (clock),
    .resetn       (resetn),
    .out_mode     (ch4_ctl_r[`TCC_OMODE_HI:`TCC_OMODE_LO]), // R7
    .drive_bit    (ch4_ctl_r[`TCC_DRIVE_BIT]), // R10
    .match_pulse  (ch4_match_pulse),
    .period_pulse (period_pulse),
    .out_level    (ch4_out)
  );

endmodule // tcc_channel_ctl
`default_nettype wire

// file: tcc_map.vh
// Register map, field positions and constants of the capture/compare channel block
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// =========================================================
// Register indices; the APB byte address is four times the index
`define TCC_CH3_CTL_OFF    12'h168
`define TCC_CH4_CTL_OFF    12'h16A
`define TCC_IRQ_STAT_OFF   12'h170
`define TCC_IRQ_MASK_OFF   12'h174

// =========================================================
// Byte addresses on APB (printed offsets are not all multiples of four)
`define TCC_CH3_CTL_ADDR   12'h5A0
`define TCC_CH4_CTL_ADDR   12'h5A8
`define TCC_IRQ_STAT_ADDR  12'h5C0
`define TCC_IRQ_MASK_ADDR  12'h5D0

// =========================================================
// Control register fields
`define TCC_EDGE_HI        15
`define TCC_EDGE_LO        14
`define TCC_SRC_HI         13
`define TCC_SRC_LO         12
`define TCC_SYNC_BIT       11
`define TCC_LATCH_BIT      10
`define TCC_RSVD_BIT       9
`define TCC_MODE_BIT       8
`define TCC_OMODE_HI       7
`define TCC_OMODE_LO       5
`define TCC_IE_BIT         4
`define TCC_LIVE_BIT       3
`define TCC_DRIVE_BIT      2
`define TCC_OVR_BIT        1
`define TCC_FLAG_BIT       0

// Bits that software may write
`define TCC_CTL_WMASK      16'hF9F7
`define TCC_CTL_RESET      16'h0000

// =========================================================
// Encodings
`define TCC_EDGE_NONE      2'h0
`define TCC_EDGE_RISE      2'h1
`define TCC_EDGE_FALL      2'h2
`define TCC_EDGE_BOTH      2'h3
`define TCC_SRC_A          2'h0
`define TCC_SRC_B          2'h1
`define TCC_SRC_GND        2'h2
`define TCC_SRC_VCC        2'h3

// Interrupt status bits: [1:0] event ch3/ch4, [3:2] overrun ch3/ch4
`define TCC_IRQ_W          4
`define TCC_IRQ_RESET      4'h0

`endif

// file: tcc_out_unit.v
// Output mode unit of one capture/compare channel
`timescale 1ns/1ps
`default_nettype none
module tcc_out_unit (
  input  wire       clock,
  input  wire       resetn,
  input  wire [2:0] out_mode,
  input  wire       drive_bit,
  input  wire       match_pulse,
  input  wire       period_pulse,
  output reg        out_level
);
  // =========================================================
  // Output modes: match pulse = own compare, period pulse = compare 0 / rollover
  localparam [2:0] OM_DRIVE = 3'h0;
  localparam [2:0] OM_SET   = 3'h1;
  localparam [2:0] OM_TGRST = 3'h2;
  localparam [2:0] OM_SETRS = 3'h3;
  localparam [2:0] OM_TOG   = 3'h4;
  localparam [2:0] OM_RST   = 3'h5;
  localparam [2:0] OM_TGSET = 3'h6;
  localparam [2:0] OM_RSSET = 3'h7;

  reg out_nxt;

  always @* begin
    out_nxt = out_level;
    case (out_mode)
      OM_DRIVE: out_nxt = drive_bit; // R10
      OM_SET:   if (match_pulse) out_nxt = 1'b1;
      OM_TGRST: if (match_pulse) out_nxt = ~out_level; else if (period_pulse) out_nxt = 1'b0;
      OM_SETRS: if (match_pulse) out_nxt = 1'b1; else if (period_pulse) out_nxt = 1'b0;
      OM_TOG:   if (match_pulse) out_nxt = ~out_level;
      OM_RST:   if (match_pulse) out_nxt = 1'b0;
      OM_TGSET: if (match_pulse) out_nxt = ~out_level; else if (period_pulse) out_nxt = 1'b1;
      OM_RSSET: if (match_pulse) out_nxt = 1'b0; else if (period_pulse) out_nxt = 1'b1;
      default:  out_nxt = out_level;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_level <= 1'b0;
    end else begin
      out_level <= out_nxt; // R7
    end
  end
endmodule // tcc_out_unit
`default_nettype wire

// file: tcc_chk_monitor.sv
// Concurrent checks on the ports of the capture/compare channel block
`timescale 1ns/1ps
`default_nettype none
module tcc_chk_monitor (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ch3_irq_req,
  input wire logic        ch4_irq_req,
  input wire logic        irq,
  input wire logic        ch4_out,
  input wire logic        ch3_match_pulse,
  input wire logic        ch4_match_pulse,
  input wire logic        period_pulse,
  input wire logic        ch3_capture_pulse
);
  // ==========================================
  // Helpers
  logic       wr_acc;
  logic [2:0] cause_r;
  assign wr_acc = psel && penable && pwrite;
  // Output lags its cause by up to three edges
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cause_r <= 3'h0;
    end else begin
      cause_r <= {cause_r[1:0], wr_acc | ch4_match_pulse | period_pulse};
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Assertions
  pready_high_a: assert property (pready)
    else $error("pready low");
  map_err_a: assert property (psel && penable |-> pslverr ==
    !(paddr inside {12'h5A0, 12'h5A8, 12'h5C0, 12'h5D0})) else $error("pslverr wrong");
  rsvd_zero_a: assert property (psel && penable && !pwrite |->
    prdata[31:16] == 16'h0000 && prdata[9] == 1'h0) else $error("reserved bit set");
  irq3_rise_a: assert property ($rose(ch3_irq_req) |-> $past(wr_acc) ||
    $past(ch3_match_pulse) || $past(ch3_match_pulse, 2) || ch3_capture_pulse
    or ##1 ch3_capture_pulse) else $error("ch3 request without cause");
  irq3_fall_a: assert property ($fell(ch3_irq_req) |-> $past(wr_acc))
    else $error("ch3 request dropped by itself");
  irq4_fall_a: assert property ($fell(ch4_irq_req) |-> $past(wr_acc))
    else $error("ch4 request dropped by itself");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc))
    else $error("interrupt dropped by itself");
  out_cause_a: assert property ($changed(ch4_out) |-> cause_r != 3'h0)
    else $error("ch4 output moved without cause");
endmodule // tcc_chk_monitor
`default_nettype wire

// file: tb.sv
// Self-checking testbench of the capture/compare channel block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================
  // Signals
  logic             clock, resetn, psel, penable, pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, rd;
  logic             a3, b3, a4, b4, m3, m4, pp;
  wire logic        pready, pslverr, o3, o4, q3, q4, irq, c3;
  int               n_cap3;
  wire logic [31:0] prdata;
  int               failures, num_checks;
  logic [7:0]       e1 = 8'h5E;
  logic [7:0]       e2 = 8'hD2;

  tcc_channel_ctl DUT (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .ch3_input_a_line(a3), .ch3_input_b_line(b3), .ch4_input_a_line(a4),
    .ch4_input_b_line(b4), .ch3_match_pulse(m3), .ch4_match_pulse(m4), .period_pulse(pp),
    .ch3_capture_pulse(c3), .ch4_capture_pulse(), .ch3_out(o3), .ch4_out(o4),
    .ch3_irq_req(q3), .ch4_irq_req(q4), .irq);

  // ==========================================
  // Tasks
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      failures++;
      give_verdict;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, d, 1'h1);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(a, 32'h0, 1'h0);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Match pulse of channel 4 or period pulse, one cycle wide
  task automatic pulse(input logic per);
    @(posedge clock);
    if (per) pp <= 1'h1;
    else m4 <= 1'h1;
    @(posedge clock);
    pp <= 1'h0;
    m4 <= 1'h0;
  endtask

  // Counts one-cycle capture pulses of channel 3
  always @(posedge clock) begin
    if (resetn && c3 === 1'h1) n_cap3++;
  end

  // ==========================================
  // Clock and sequence
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    {resetn, psel, penable, pwrite, a3, b3, a4, b4, m3, m4, pp} = 11'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    failures = 0;
    num_checks = 0;
    n_cap3 = 0;
    cyc(10);
    resetn <= 1'h1;
    rdchk(12'h5A0, 32'h0);
    rdchk(12'h5A8, 32'h0);
    rdchk(12'h100, 32'h0);
    // Read-only bits must ignore the all-ones write
    wr(12'h5A8, 32'hFFFFFFFF);
    cyc(8);
    rdchk(12'h5A8, 32'hF9FF);
    @(negedge clock) chk(q4, 1'h1);
    wr(12'h5A8, 32'h0);
    cyc(8);
    rdchk(12'h5A8, 32'h0);
    a3 <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      wr(12'h5A0, s << 12);
      cyc(6);
      rdchk(12'h5A0, (s << 12) | ((s == 0 || s == 3) << 3));
    end
    for (int e = 0; e < 4; e++) begin
      a3 <= 1'h0;
      wr(12'h5A0, (e << 14) | 32'h100);
      cyc(8);
      wr(12'h5A0, (e << 14) | 32'h100);
      a3 <= 1'h1;
      cyc(8);
      rdchk(12'h5A0, (e << 14) | 32'h108 | e[0]);
      @(negedge clock) chk(q3, 1'h0);
      wr(12'h5A0, (e << 14) | 32'h108);
      a3 <= 1'h0;
      cyc(8);
      rdchk(12'h5A0, (e << 14) | 32'h100 | e[1]);
    end
    // Two captures without clearing the flag
    wr(12'h5A0, 32'hC110);
    wr(12'h5C0, 32'hF);
    a3 <= 1'h1;
    cyc(8);
    a3 <= 1'h0;
    cyc(8);
    rdchk(12'h5A0, 32'hC113);
    chk(n_cap3, 32'h6);
    @(negedge clock) chk({q3, irq}, 2'h2);
    rdchk(12'h5C0, 32'h5);
    wr(12'h5D0, 32'h4);
    @(negedge clock) chk(irq, 1'h1);
    wr(12'h5C0, 32'h4);
    @(negedge clock) chk(irq, 1'h0);
    rdchk(12'h5C0, 32'h1);
    wr(12'h5A0, 32'hC100);
    rdchk(12'h5A0, 32'hC100);
    // Compare mode: a match of channel 3 sets its flag
    wr(12'h5A0, 32'h0);
    @(posedge clock);
    m3 <= 1'h1;
    @(posedge clock);
    m3 <= 1'h0;
    cyc(2);
    rdchk(12'h5A0, 32'h1);
    wr(12'h5A0, 32'h0);
    // Latched input follows the source at each match
    wr(12'h5A8, 32'h3000);
    cyc(6);
    pulse(1'h0);
    cyc(3);
    rdchk(12'h5A8, 32'h3409);
    wr(12'h5A8, 32'h2000);
    cyc(6);
    pulse(1'h0);
    cyc(3);
    rdchk(12'h5A8, 32'h2001);
    wr(12'h5A8, 32'h4);
    cyc(3);
    @(negedge clock) chk(o4, 1'h1);
    for (int m = 0; m < 8; m++) begin
      wr(12'h5A8, 32'h0);
      cyc(3);
      wr(12'h5A8, m << 5);
      cyc(3);
      pulse(1'h0);
      cyc(3);
      @(negedge clock) chk(o4, e1[m]);
      pulse(1'h1);
      cyc(3);
      @(negedge clock) chk(o4, e2[m]);
    end
    give_verdict;
  end
endmodule // tb

bind tcc_channel_ctl tcc_chk_monitor u_mon (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .ch3_irq_req, .ch4_irq_req, .irq, .ch4_out, .ch3_match_pulse,
  .ch4_match_pulse, .period_pulse, .ch3_capture_pulse);
`default_nettype wire
